/* design/dsrw_pkg.sv */
package dsrw_pkg;
   // Group geometry: cells per group (14 or 12) and number of groups.
   localparam int DSRW_CELLS_MAX = 14;
   localparam int DSRW_CELLS_MIN = 12;
   localparam int DSRW_GROUPS = 2;
   // Widest memory data path carried by both groups together.
   localparam int DSRW_DQ_MAX = 16;
   localparam int DSRW_DQ_PER_GROUP = DSRW_DQ_MAX / DSRW_GROUPS;
   // Calibration code width from the edge DLL.
   localparam int DSRW_CAL_W = 6;
   // Clock figures.
   localparam int DSRW_SYS_PERIOD_NS = 20;
   // Strobe read quadrature delay in system cycles after a sampled strobe edge.
   localparam int DSRW_RD_SHIFT_CYC = 1;
   // Burst length in strobe edges (beats) per read; default figure, may differ.
   localparam int DSRW_BURST_BEATS = 4;
   // DLL lock: consecutive matching feedback samples needed.
   localparam int DSRW_DLL_LOCK_CNT = 8;
   localparam logic [DSRW_CAL_W-1:0] DSRW_CAL_RST = 6'h20;
endpackage : dsrw_pkg

/* design/dsrw_dll.sv */
`timescale 1ns/1ps
// Calibration loop: compares the system clock reference against its delayed feedback
// and steps a 6-bit code until the two agree.
module dsrw_dll
   import dsrw_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_srst,
   input wire logic i_fb_early,
   input wire logic i_fb_late,
   output logic [DSRW_CAL_W-1:0] o_cal_code,
   output logic o_locked
);
   logic [DSRW_CAL_W-1:0] code_q;
   logic [3:0] match_q;
   wire step_up = i_fb_early & ~i_fb_late & (code_q != 6'h3f);
   wire step_dn = i_fb_late & ~i_fb_early & (code_q != 6'h00);
   wire balanced = ~(i_fb_early ^ i_fb_late);

   // The code moves one step per cycle so the delay line never jumps mid-burst.
   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst)
      begin
         code_q <= DSRW_CAL_RST;
         match_q <= 4'h0;
      end
      else
      begin
         if (step_up)
            code_q <= code_q + 6'h01;
         else if (step_dn)
            code_q <= code_q - 6'h01;
         if (!balanced)
            match_q <= 4'h0;
         else if (match_q != 4'(DSRW_DLL_LOCK_CNT))
            match_q <= match_q + 4'h1;
      end
   end

   assign o_cal_code = code_q;
   assign o_locked = (match_q == 4'(DSRW_DLL_LOCK_CNT));
endmodule : dsrw_dll

/* design/dsrw_top.sv */
`timescale 1ns/1ps
// Function
// - Two cell groups, one control element each.
// - Data path at most sixteen bits wide.
// - Four outputs: read, write, polarity, valid.
// - Shifted read strobe derived from incoming strobe; shifted write strobe toggles on the system clock.
// - Polarity re-evaluated at every read start.
// - First rising edge after preamble sets polarity.
// - Polarity selects sync register clock edge.
// - Delay takes 6-bit DLL calibration code.
// - DLL compensates using system clock feedback.
// - Read data captured on both strobe edges.
// - Captured streams resynchronised to system clock.
// - Write mux switched by shifted write strobe.
// - Output enable registered on write strobe.
module dsrw_top
   import dsrw_pkg::*;
#(
   parameter int GROUP_W = DSRW_DQ_PER_GROUP,
   parameter int BURST_BEATS = DSRW_BURST_BEATS
)
(
   input wire logic i_clk_sys,
   input wire logic i_srst,
   input wire logic [DSRW_GROUPS-1:0] i_dqs_in,
   input wire logic [DSRW_GROUPS-1:0] i_dqs_driven,
   input wire logic [DSRW_GROUPS*GROUP_W-1:0] i_dq_in,
   input wire logic [DSRW_GROUPS-1:0] i_read_start,
   input wire logic [DSRW_GROUPS-1:0] i_write_en,
   input wire logic [DSRW_GROUPS*GROUP_W-1:0] i_wr_rise,
   input wire logic [DSRW_GROUPS*GROUP_W-1:0] i_wr_fall,
   input wire logic [DSRW_GROUPS-1:0] i_wr_tristate,
   input wire logic i_fb_early,
   input wire logic i_fb_late,
   output logic [DSRW_GROUPS-1:0] o_read_strobe_shifted,
   output logic [DSRW_GROUPS-1:0] o_write_strobe_shifted,
   output logic [DSRW_GROUPS-1:0] o_sync_clock_polarity_select,
   output logic [DSRW_GROUPS-1:0] o_read_valid_flag,
   output logic [DSRW_GROUPS*GROUP_W-1:0] o_rd_rise,
   output logic [DSRW_GROUPS*GROUP_W-1:0] o_rd_fall,
   output logic [DSRW_GROUPS*GROUP_W-1:0] o_dq_out,
   output logic [DSRW_GROUPS*GROUP_W-1:0] o_dq_oe_n,
   output logic [DSRW_GROUPS-1:0] o_dqs_out,
   output logic [DSRW_GROUPS-1:0] o_dqs_oe_n,
   output logic [DSRW_CAL_W-1:0] o_cal_code,
   output logic o_dll_locked
);
   logic [DSRW_CAL_W-1:0] cal_w;
   logic locked_w;

   // One calibration loop serves both groups.
   dsrw_dll i_dsrw_dll (
      .i_clk_sys(i_clk_sys),
      .i_srst(i_srst),
      .i_fb_early(i_fb_early),
      .i_fb_late(i_fb_late),
      .o_cal_code(cal_w),
      .o_locked(locked_w)
   );

   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst)
      begin
         o_cal_code <= DSRW_CAL_RST;
         o_dll_locked <= 1'b0;
      end
      else
      begin
         o_cal_code <= cal_w;
         o_dll_locked <= locked_w;
      end
   end

   // Each group has one control element whose outputs fan to all its cells.
   for (genvar g = 0; g < DSRW_GROUPS; g++)
   begin : g_grp
      typedef enum logic [1:0] {ST_IDLE, ST_PRE, ST_BURST} dsrw_rd_e;
      dsrw_rd_e st_q;
      logic [2:0] dqs_sync_q;
      logic [2:0] drv_sync_q;
      logic [3*GROUP_W-1:0] dq_sync_q;
      logic dqs_lvl_q;
      logic [DSRW_CAL_W-1:0] dly_cnt_q;
      logic rd_shift_q;
      logic wr_shift_q;
      logic pol_q;
      logic valid_q;
      logic [7:0] beat_q;
      logic [GROUP_W-1:0] cap_r_q;
      logic [GROUP_W-1:0] cap_f_q;
      logic [GROUP_W-1:0] rd_r_q;
      logic [GROUP_W-1:0] rd_f_q;
      logic [GROUP_W-1:0] wr_r_q;
      logic [GROUP_W-1:0] wr_f_q;
      logic oe_n_q;
      logic dqs_out_q;
      logic phase_q;

      // A strobe level counts once the second and third samples agree.
      wire dqs_agree = (dqs_sync_q[1] == dqs_sync_q[2]);
      wire dqs_rise = dqs_agree & dqs_sync_q[2] & ~dqs_lvl_q;
      wire dqs_fall = dqs_agree & ~dqs_sync_q[2] & dqs_lvl_q;
      wire dqs_edge = dqs_rise | dqs_fall;
      wire drv_ok = (drv_sync_q[1] == drv_sync_q[2]) & drv_sync_q[2];
      wire [GROUP_W-1:0] dq_now = dq_sync_q[3*GROUP_W-1:2*GROUP_W];
      wire dly_done = (dly_cnt_q == 6'h00);
      wire last_beat = (beat_q == 8'(BURST_BEATS - 1));

      // Input synchronisers: stage 0 feeds only stage 1.
      always_ff @(posedge i_clk_sys)
      begin
         if (i_srst)
         begin
            dqs_sync_q <= 3'h0;
            drv_sync_q <= 3'h0;
            dq_sync_q <= '0;
         end
         else
         begin
            dqs_sync_q <= {dqs_sync_q[1:0], i_dqs_in[g]};
            drv_sync_q <= {drv_sync_q[1:0], i_dqs_driven[g]};
            dq_sync_q <= {dq_sync_q[2*GROUP_W-1:0], i_dq_in[g*GROUP_W +: GROUP_W]};
         end
      end

      // The shifted read strobe follows the incoming strobe after a delay set by the
      // calibration code; it is not gated by the read sequencer, so it tracks any settled strobe level.
      always_ff @(posedge i_clk_sys)
      begin
         if (i_srst)
         begin
            dqs_lvl_q <= 1'b0;
            dly_cnt_q <= '0;
            rd_shift_q <= 1'b0;
         end
         else
         begin
            if (dqs_agree)
               dqs_lvl_q <= dqs_sync_q[2];
            if (dqs_edge)
               dly_cnt_q <= 6'(DSRW_RD_SHIFT_CYC - 1) + (cal_w >> 5);
            else if (!dly_done)
               dly_cnt_q <= dly_cnt_q - 6'h01;
            if (dly_done && (dqs_lvl_q != rd_shift_q))
               rd_shift_q <= dqs_lvl_q;
         end
      end

      // Read sequencer: parked strobe, preamble low, first rise fixes the polarity.
      always_ff @(posedge i_clk_sys)
      begin
         if (i_srst)
         begin
            st_q <= ST_IDLE;
            pol_q <= 1'b0;
            beat_q <= 8'h00;
            valid_q <= 1'b0;
         end
         else
         begin
            valid_q <= 1'b0;
            case (st_q)
               ST_IDLE:
               begin
                  beat_q <= 8'h00;
                  if (i_read_start[g])
                     st_q <= ST_PRE;
               end
               ST_PRE:
               begin
                  // Waits for the driven-low preamble before trusting a rise.
                  if (drv_ok && dqs_rise)
                  begin
                     pol_q <= phase_q;
                     // The first rise is beat one, so the burst ends on its own last edge.
                     beat_q <= 8'h01;
                     st_q <= ST_BURST;
                  end
               end
               ST_BURST:
               begin
                  if (dqs_edge)
                  begin
                     valid_q <= dqs_fall;
                     beat_q <= beat_q + 8'h01;
                     if (last_beat)
                        st_q <= ST_IDLE;
                  end
               end
               default: st_q <= ST_IDLE;
            endcase
         end
      end

      // Free phase toggle of the system clock, sampled by the first rising strobe.
      always_ff @(posedge i_clk_sys)
      begin
         if (i_srst)
            phase_q <= 1'b0;
         else
            phase_q <= ~phase_q;
      end

      // Capture on both strobe edges, then move to the system domain.
      always_ff @(posedge i_clk_sys)
      begin
         if (i_srst)
         begin
            cap_r_q <= '0;
            cap_f_q <= '0;
            rd_r_q <= '0;
            rd_f_q <= '0;
         end
         else
         begin
            if (dqs_rise)
               cap_r_q <= dq_now;
            if (dqs_fall)
               cap_f_q <= dq_now;
            // The pair moves across together on the fall that completes it.
            if (dqs_fall)
            begin
               rd_r_q <= cap_r_q;
               rd_f_q <= dq_now;
            end
         end
      end

      // Write path: strobe toggles each cycle, data mux follows it, enable registered.
      always_ff @(posedge i_clk_sys)
      begin
         if (i_srst)
         begin
            wr_shift_q <= 1'b0;
            wr_r_q <= '0;
            wr_f_q <= '0;
            oe_n_q <= 1'b1;
            dqs_out_q <= 1'b0;
         end
         else
         begin
            wr_shift_q <= i_write_en[g] ? ~wr_shift_q : 1'b0;
            dqs_out_q <= wr_shift_q;
            if (!wr_shift_q)
            begin
               wr_r_q <= i_wr_rise[g*GROUP_W +: GROUP_W];
               wr_f_q <= i_wr_fall[g*GROUP_W +: GROUP_W];
            end
            if (wr_shift_q || !i_write_en[g])
               oe_n_q <= i_wr_tristate[g] | ~i_write_en[g];
         end
      end

      // Registered outputs of the group; the data path is at most sixteen bits.
      always_ff @(posedge i_clk_sys)
      begin
         if (i_srst)
         begin
            o_read_strobe_shifted[g] <= 1'b0;
            o_write_strobe_shifted[g] <= 1'b0;
            o_sync_clock_polarity_select[g] <= 1'b0;
            o_read_valid_flag[g] <= 1'b0;
            o_rd_rise[g*GROUP_W +: GROUP_W] <= '0;
            o_rd_fall[g*GROUP_W +: GROUP_W] <= '0;
            o_dq_out[g*GROUP_W +: GROUP_W] <= '0;
            o_dq_oe_n[g*GROUP_W +: GROUP_W] <= '1;
            o_dqs_out[g] <= 1'b0;
            o_dqs_oe_n[g] <= 1'b1;
         end
         else
         begin
            o_read_strobe_shifted[g] <= rd_shift_q;
            o_write_strobe_shifted[g] <= wr_shift_q;
            o_sync_clock_polarity_select[g] <= pol_q;
            o_read_valid_flag[g] <= valid_q;
            o_rd_rise[g*GROUP_W +: GROUP_W] <= rd_r_q;
            o_rd_fall[g*GROUP_W +: GROUP_W] <= rd_f_q;
            o_dq_out[g*GROUP_W +: GROUP_W] <= wr_shift_q ? wr_f_q : wr_r_q;
            o_dq_oe_n[g*GROUP_W +: GROUP_W] <= {GROUP_W{oe_n_q}};
            o_dqs_out[g] <= dqs_out_q;
            o_dqs_oe_n[g] <= oe_n_q;
         end
      end
   end
endmodule : dsrw_top

/* tb/dsrw_properties.sv */
`timescale 1ns/1ps
// Watches group 0 of the strobe block; group 1 is a copy of the same logic.
module dsrw_properties
   import dsrw_pkg::*;
#(
   parameter int GROUP_W = DSRW_DQ_PER_GROUP
)
(
   input wire logic i_clk_sys,
   input wire logic i_srst,
   input wire logic [DSRW_GROUPS-1:0] i_read_start,
   input wire logic [DSRW_GROUPS-1:0] i_write_en,
   input wire logic [DSRW_GROUPS-1:0] o_read_strobe_shifted,
   input wire logic [DSRW_GROUPS-1:0] o_write_strobe_shifted,
   input wire logic [DSRW_GROUPS-1:0] o_sync_clock_polarity_select,
   input wire logic [DSRW_GROUPS-1:0] o_read_valid_flag,
   input wire logic [DSRW_GROUPS*GROUP_W-1:0] o_rd_fall,
   input wire logic [DSRW_GROUPS*GROUP_W-1:0] o_dq_oe_n,
   input wire logic [DSRW_CAL_W-1:0] o_cal_code
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_srst);
   // Reset state is judged at the first edge after release, so the check is not disabled.
   a_reset_values: assert property (
      $fell(i_srst) |-> o_cal_code == DSRW_CAL_RST && &o_dq_oe_n)
      else $error("outputs not at reset values");
   a_valid_pulse: assert property (o_read_valid_flag[0] |=> !o_read_valid_flag[0])
      else $error("read valid lasted more than one cycle");
   // The shifted strobe lags the detected edge, so its fall follows the valid pulse.
   a_valid_after_fall: assert property (
      o_read_valid_flag[0] |-> ##[1:3] !o_read_strobe_shifted[0])
      else $error("shifted strobe did not fall after read valid");
   a_fall_data_valid: assert property (
      $changed(o_rd_fall[GROUP_W-1:0]) |-> o_read_valid_flag[0])
      else $error("read data changed without valid");
   a_pol_on_rise: assert property (
      $changed(o_sync_clock_polarity_select[0]) |-> ##[1:3] o_read_strobe_shifted[0])
      else $error("polarity changed away from a strobe rise");
   a_pol_hold_start: assert property (
      i_read_start[0] |=> $stable(o_sync_clock_polarity_select[0]) [*2])
      else $error("polarity changed before the first strobe rise");
   a_wstrobe_toggle: assert property (
      i_write_en[0] [*2] |=> o_write_strobe_shifted[0] != $past(o_write_strobe_shifted[0]))
      else $error("write strobe did not toggle");
   // The loop must walk the code one step at a time so the delay line never jumps.
   a_cal_step: assert property (
      $changed(o_cal_code) |-> (o_cal_code - $past(o_cal_code) == 6'h01)
         || ($past(o_cal_code) - o_cal_code == 6'h01))
      else $error("calibration code jumped");
   c_valid: cover property (o_read_valid_flag[0]);
   c_pol: cover property ($changed(o_sync_clock_polarity_select[0]));
   c_write: cover property (!o_dq_oe_n[0]);
endmodule : dsrw_properties

bind dsrw_top dsrw_properties #(.GROUP_W(GROUP_W)) i_dsrw_properties (
   .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_read_start(i_read_start),
   .i_write_en(i_write_en), .o_read_strobe_shifted(o_read_strobe_shifted),
   .o_write_strobe_shifted(o_write_strobe_shifted),
   .o_sync_clock_polarity_select(o_sync_clock_polarity_select),
   .o_read_valid_flag(o_read_valid_flag), .o_rd_fall(o_rd_fall),
   .o_dq_oe_n(o_dq_oe_n), .o_cal_code(o_cal_code)
);

/* tb/dsrw_mem_model.sv */
`timescale 1ns/1ps
// Memory side of the strobe link for both groups: parks the strobe, then runs read bursts.
module dsrw_mem_model
   import dsrw_pkg::*;
#(
   parameter int BURST_BEATS = DSRW_BURST_BEATS,
   parameter int HALF_NS = 80
)
(
   output logic [DSRW_GROUPS-1:0] o_dqs,
   output logic [DSRW_GROUPS-1:0] o_driven,
   output logic [DSRW_DQ_MAX-1:0] o_dq
);
   logic park = 1'b1;
   // A parked strobe floats at termination level, so it shows a level that moves every cycle.
   // The toggles sit off the burst start times so a new burst never races them.
   initial
   begin
      o_dqs = '0;
      o_driven = '0;
      o_dq = '0;
      #5;
      forever
      begin
         #20;
         if (park)
         begin
            o_dqs = ~o_dqs;
            o_dq = ~o_dq;
         end
      end
   end
   // Data is centred between strobe edges so either capture edge sees a settled beat.
   task automatic read_burst(input logic [8*BURST_BEATS-1:0] beats);
      park = 1'b0;
      o_driven = '1;
      o_dqs = '0;
      #(2*HALF_NS);
      for (int i = 0; i < BURST_BEATS; i++)
      begin
         o_dq = {DSRW_GROUPS{beats[8*i +: 8]}};
         #(HALF_NS/2);
         o_dqs = ~o_dqs;
         #(HALF_NS/2);
      end
      #(HALF_NS);
      o_driven = '0;
      park = 1'b1;
   endtask : read_burst
endmodule : dsrw_mem_model

/* tb/tb_dsrw_top.sv */
`timescale 1ns/1ps
// Runs the strobe block through reset, two read bursts, a write burst and calibration.
module tb_dsrw_top
   import dsrw_pkg::*;
   ;
   logic i_clk_sys = 1'b0;
   logic i_srst = 1'b1;
   logic [1:0] i_read_start = '0, i_write_en = '0, i_wr_tristate = '1;
   logic [15:0] i_wr_rise = 16'h3c3c, i_wr_fall = 16'hc5c5;
   logic i_fb_early = 1'b0, i_fb_late = 1'b0;
   logic [1:0] dqs, drv, rs, ws, pol, vld, dqs_out, dqs_oe_n, p0, p1;
   logic [15:0] dq, rd_r, rd_f, dq_out, dq_oe_n;
   logic [5:0] cal;
   logic lock;
   int miscompares = 0, checked = 0;
   initial
      forever #10 i_clk_sys = ~i_clk_sys;
   dsrw_top i_dsrw_top (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_dqs_in(dqs),
      .i_dqs_driven(drv), .i_dq_in(dq), .i_read_start(i_read_start), .i_write_en(i_write_en),
      .i_wr_rise(i_wr_rise), .i_wr_fall(i_wr_fall), .i_wr_tristate(i_wr_tristate),
      .i_fb_early(i_fb_early), .i_fb_late(i_fb_late), .o_read_strobe_shifted(rs),
      .o_write_strobe_shifted(ws), .o_sync_clock_polarity_select(pol),
      .o_read_valid_flag(vld), .o_rd_rise(rd_r), .o_rd_fall(rd_f), .o_dq_out(dq_out),
      .o_dq_oe_n(dq_oe_n), .o_dqs_out(dqs_out), .o_dqs_oe_n(dqs_oe_n), .o_cal_code(cal),
      .o_dll_locked(lock));
   dsrw_mem_model i_dsrw_mem_model (.o_dqs(dqs), .o_driven(drv), .o_dq(dq));
   // One comparison; a mismatch is reported at once and counted.
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic finish_test();
      $display("miscompares %0d checked %0d", miscompares, checked);
      if (miscompares == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : finish_test
   task automatic sc_reset();
      repeat (20) @(negedge i_clk_sys);
      check("cal code", 16'(cal), 16'(DSRW_CAL_RST));
      check("dq oe", dq_oe_n, 16'hffff);
      check("strobe oe", 16'(dqs_oe_n), 16'h0003);
      check("valid", 16'(vld), 16'h0000);
      i_srst = 1'b0;
   endtask : sc_reset
   // Each read checks every beat pair and both groups, which share one strobe.
   task automatic sc_read(input int lag, output logic [1:0] p);
      logic [31:0] beats;
      int k;
      beats = 32'h5ac3_a53c ^ {4{8'(lag)}};
      k = 0;
      @(negedge i_clk_sys);
      i_read_start = 2'h3;
      @(negedge i_clk_sys);
      i_read_start = 2'h0;
      fork
         begin
            #(lag);
            i_dsrw_mem_model.read_burst(beats);
         end
         repeat (60)
         begin
            @(negedge i_clk_sys);
            if (vld[0] === 1'b1 && k < 2)
            begin
               check("rise data", rd_r, {2{beats[16*k +: 8]}});
               check("fall data", rd_f, {2{beats[16*k+8 +: 8]}});
               k++;
            end
            else if (vld[0] === 1'b1)
               k++;
         end
      join
      check("pairs", 16'(k), 16'(DSRW_BURST_BEATS/2));
      check("group polarity", 16'(pol[1]), 16'(pol[0]));
      p = pol;
      // A burst that never completed leaves the sequencer stuck, so stop here.
      if (k != DSRW_BURST_BEATS/2)
         finish_test();
   endtask : sc_read
   // The data mux and the strobe pin both follow the shifted write strobe.
   task automatic sc_write();
      int r, f, oe, tog, mux, ptog;
      logic last, plast;
      {r, f, oe, tog, mux, ptog} = '0;
      i_wr_tristate = 2'h0;
      i_write_en = 2'h3;
      last = ws[0];
      plast = dqs_out[0];
      repeat (12)
      begin
         @(negedge i_clk_sys);
         r += int'(dq_out === i_wr_rise);
         f += int'(dq_out === i_wr_fall);
         oe += int'(dq_oe_n === 16'h0000);
         mux += int'(dq_out === (ws[0] ? i_wr_fall : i_wr_rise));
         tog += int'(ws[0] !== last);
         ptog += int'(dqs_out[0] !== plast);
         last = ws[0];
         plast = dqs_out[0];
      end
      check("strobe toggles", 16'(tog > 8), 16'h0001);
      check("strobe pin toggles", 16'(ptog > 8), 16'h0001);
      check("rise half", 16'(r > 0), 16'h0001);
      check("fall half", 16'(f > 0), 16'h0001);
      check("mux follows strobe", 16'(mux), 16'h000c);
      check("drive", 16'(oe > 0), 16'h0001);
      check("strobe pin drive", 16'(dqs_oe_n), 16'h0000);
      i_write_en = 2'h0;
      i_wr_tristate = 2'h3;
      repeat (6) @(negedge i_clk_sys);
      check("release", dq_oe_n, 16'hffff);
      check("strobe pin release", 16'(dqs_oe_n), 16'h0003);
   endtask : sc_write
   task automatic sc_dll();
      int n;
      i_fb_early = 1'b1;
      repeat (10) @(negedge i_clk_sys);
      check("cal moved", 16'(cal !== DSRW_CAL_RST), 16'h0001);
      i_fb_early = 1'b0;
      for (n = 0; n < 40 && lock !== 1'b1; n++)
         @(negedge i_clk_sys);
      check("locked", 16'(lock), 16'h0001);
      if (n == 40)
         finish_test();
   endtask : sc_dll
   initial
   begin
      sc_reset();
      sc_read(0, p0);
      sc_read(20, p1);
      // A start one cycle later lands the first rise on the other system phase.
      check("polarity", 16'(p1 ^ p0), 16'h0003);
      sc_write();
      sc_dll();
      finish_test();
   end
endmodule : tb_dsrw_top
